/* File: logic/input_gain_update_control.sv */
// Input gain stage control: staged gain codes, global apply strobe, crossing gate
//
// How it works
// - Four stages, each -16.5 dB to +30 dB in 1.5 dB steps, independent.
// - Code 00000 is minimum gain, each increment one step, 11111 maximum.
// - Inverting and non-inverting inputs both take the stage's single code.
// - Silence bit 7 per stage, 1 mutes, resets to 1.
// - Crossing gate bit 6 resets 0; 0 applies now, 1 waits crossing.
// - With gate set, a pending change waits for a detected zero crossing.
// - With timeout enabled, pending change applies when the period expires.
// - Timeout length comes from a separate period setting, not gain registers.
// - Write with update bit 0 stores the code, applied gain unchanged.
// - Update bit 1 transfers all four stored codes together, per-stage gating.
// - Update bit 8 exists in all four stage registers, same effect each.
// - Gain code bits 4:0 reset to 01011, unity gain.
`timescale 1ns/1ps
module input_gain_update_control (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [3:0]  i_zero_cross,
  output logic [19:0]      o_inv_gain_code,
  output logic [19:0]      o_noninv_gain_code,
  output logic [3:0]       o_stage_silence
);

  // Register index of each stage, in stage order
  function automatic logic [7:0] stage_idx(input int s);
    case (s)
      0:       stage_idx = gain_pkg::IDX_LEFT_A;
      1:       stage_idx = gain_pkg::IDX_LEFT_B;
      2:       stage_idx = gain_pkg::IDX_RIGHT_A;
      default: stage_idx = gain_pkg::IDX_RIGHT_B;
    endcase
  endfunction : stage_idx

  gain_pkg::bus_state_e        bus_r;
  gain_pkg::bus_state_e        bus_nxt;
  logic [31:0]                 rdata_r;
  logic [31:0]                 rdata_nxt;
  gain_pkg::stage_cfg_s [3:0]  cfg_r;
  logic [4:0]                  applied_r [4];
  logic [3:0]                  pending_r;
  logic [14:0]                 tmo_cnt_r [4];
  logic                        to_en_r;
  logic [14:0]                 period_r;
  logic [19:0]                 inv_r;
  logic [19:0]                 noninv_r;
  logic [3:0]                  silence_out_r;
  logic                        req;
  logic                        rd_take;
  logic                        accept;
  logic                        wr_acc;
  logic [5:0]                  word_idx;
  logic                        in_range;
  logic [3:0]                  sel_stage;
  logic [3:0]                  wr_stage;
  logic [3:0]                  apply_strobe;
  logic                        gain_apply_strobe;
  logic                        wr_timeout;
  logic [3:0]                  load_now;
  logic [3:0]                  tmo_hit;
  logic [31:0]                 stage_rd [4];
  logic [31:0]                 status_rd;

  // Byte address to register index; low two bits must be zero
  assign word_idx = i_avs_address[7:2];
  assign in_range = (i_avs_address[1:0] == 2'h0);
  assign req      = i_avs_read | i_avs_write;
  assign accept   = (bus_r == gain_pkg::ST_WAIT);
  assign wr_acc   = accept & i_avs_write;
  assign rd_take  = (bus_r == gain_pkg::ST_IDLE) & i_avs_read;

  // One wait state per access: request seen in IDLE, completed in WAIT
  always_comb begin
    bus_nxt = bus_r;
    case (bus_r)
      gain_pkg::ST_IDLE: bus_nxt = req ? gain_pkg::ST_WAIT : gain_pkg::ST_IDLE;
      gain_pkg::ST_WAIT: bus_nxt = gain_pkg::ST_DONE;
      gain_pkg::ST_DONE: bus_nxt = gain_pkg::ST_IDLE;
      default:           bus_nxt = gain_pkg::ST_IDLE;
    endcase
  end

  // Per-stage decode and read views
  genvar g;
  generate
    for (g = 0; g < gain_pkg::NUM_STAGES; g++) begin : g_dec
      assign sel_stage[g]    = in_range & ({2'h0, word_idx} == stage_idx(g));
      assign wr_stage[g]     = wr_acc & sel_stage[g] & i_avs_byteenable[0];
      // Update bit lives in the second byte lane
      assign apply_strobe[g] = wr_acc & sel_stage[g] & i_avs_byteenable[1]
                             & i_avs_writedata[gain_pkg::BIT_UPDATE];
      // Update bit reads zero: it is a strobe, not storage
      assign stage_rd[g]     = {24'h00_0000, cfg_r[g].silence, cfg_r[g].gate, 1'b0,
                                cfg_r[g].code};
    end
  endgenerate

  // Any stage register can fire the global transfer
  assign gain_apply_strobe = |apply_strobe;
  assign wr_timeout = wr_acc & in_range & ({2'h0, word_idx} == gain_pkg::IDX_TIMEOUT);
  assign status_rd  = {24'h00_0000, pending_r, 4'h0};

  // Read mux, loaded as the request is taken so data stands while waitrequest is low
  always_comb begin
    rdata_nxt = gain_pkg::UNMAPPED_DATA;
    if (rd_take) begin
      for (int s = 0; s < gain_pkg::NUM_STAGES; s++) begin
        if (sel_stage[s]) begin
          rdata_nxt = stage_rd[s];
        end
      end
      if (in_range && ({2'h0, word_idx} == gain_pkg::IDX_TIMEOUT)) begin
        rdata_nxt = {16'h0000, to_en_r, period_r};
      end
      if (in_range && ({2'h0, word_idx} == gain_pkg::IDX_STATUS)) begin
        rdata_nxt = status_rd;
      end
    end
  end

  // Bus handshake registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bus_r             <= gain_pkg::ST_IDLE;
      rdata_r           <= 32'h0000_0000;
      o_avs_waitrequest <= 1'b1;
    end else begin
      bus_r             <= bus_nxt;
      rdata_r           <= rdata_nxt;
      o_avs_waitrequest <= !(bus_nxt == gain_pkg::ST_WAIT);
    end
  end
  assign o_avs_readdata = rdata_r;

  // Timeout settings, kept apart from the gain registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      to_en_r  <= gain_pkg::TO_EN_RESET;
      period_r <= gain_pkg::PERIOD_RESET;
    end else if (wr_timeout) begin
      // Lanes write apart, so a one-lane write leaves the other half alone
      if (i_avs_byteenable[1]) begin
        to_en_r                          <= i_avs_writedata[gain_pkg::BIT_TO_ENABLE];
        period_r[gain_pkg::PERIOD_W-1:8] <= i_avs_writedata[gain_pkg::PERIOD_W-1:8];
      end
      if (i_avs_byteenable[0]) begin
        period_r[7:0] <= i_avs_writedata[7:0];
      end
    end
  end

  // Stage apply logic; a new strobe restarts the wait of every gated stage
  generate
    for (g = 0; g < gain_pkg::NUM_STAGES; g++) begin : g_stage
      assign tmo_hit[g]  = to_en_r & pending_r[g] & (tmo_cnt_r[g] >= period_r);
      // Ungated stages take the code at once; gated ones wait crossing or timeout
      assign load_now[g] = (gain_apply_strobe & !cfg_r[g].gate)
                         | (pending_r[g] & (i_zero_cross[g] | tmo_hit[g]));

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          cfg_r[g].silence <= gain_pkg::SILENCE_RESET;
          cfg_r[g].gate    <= gain_pkg::GATE_RESET;
          cfg_r[g].code    <= gain_pkg::CODE_RESET;
        end else if (wr_stage[g]) begin
          // Storing the code alone never moves the applied gain
          cfg_r[g].silence <= i_avs_writedata[gain_pkg::BIT_SILENCE];
          cfg_r[g].gate    <= i_avs_writedata[gain_pkg::BIT_GATE];
          cfg_r[g].code    <= i_avs_writedata[gain_pkg::CODE_MSB:0];
        end
      end

      always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          applied_r[g] <= gain_pkg::CODE_RESET;
          pending_r[g] <= 1'b0;
          tmo_cnt_r[g] <= 15'h0000;
        end else if (gain_apply_strobe && cfg_r[g].gate) begin
          pending_r[g] <= 1'b1;
          tmo_cnt_r[g] <= 15'h0000;
        end else if (load_now[g]) begin
          applied_r[g] <= cfg_r[g].code;
          pending_r[g] <= 1'b0;
          tmo_cnt_r[g] <= 15'h0000;
        end else if (pending_r[g] && to_en_r) begin
          tmo_cnt_r[g] <= tmo_cnt_r[g] + 15'h0001;
        end
      end
    end
  endgenerate

  // Outputs: one code drives both inputs of a stage; linear code to gain step
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      inv_r         <= {4{gain_pkg::CODE_RESET}};
      noninv_r      <= {4{gain_pkg::CODE_RESET}};
      silence_out_r <= {4{gain_pkg::SILENCE_RESET}};
    end else begin
      for (int s = 0; s < gain_pkg::NUM_STAGES; s++) begin
        inv_r[s*5 +: 5]    <= applied_r[s];
        noninv_r[s*5 +: 5] <= applied_r[s];
        silence_out_r[s]   <= cfg_r[s].silence;
      end
    end
  end
  assign o_inv_gain_code    = inv_r;
  assign o_noninv_gain_code = noninv_r;
  assign o_stage_silence    = silence_out_r;

  // Checks; stage indices vary so that every stage is watched somewhere
  // Both inputs of every stage see the same code
  gain_pair_equal_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_inv_gain_code == o_noninv_gain_code)
    else $error("stage input gains differ");

  // Silence bit reaches the pin two edges after the write
  silence_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stage[0] |-> ##2 o_stage_silence[0] == $past(i_avs_writedata[7], 2))
    else $error("silence bit not applied");

  // Without strobe or pending wait the applied code never moves
  store_no_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!gain_apply_strobe && !pending_r[1]) |=> $stable(applied_r[1]))
    else $error("applied gain moved without strobe");

  // Ungated stage takes the stored code on the strobe edge
  immediate_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (gain_apply_strobe && !cfg_r[2].gate) |=> applied_r[2] == $past(cfg_r[2].code))
    else $error("ungated stage not applied");

  // Gated stage only goes pending on the strobe
  gated_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (gain_apply_strobe && cfg_r[0].gate) |=> pending_r[0] && $stable(applied_r[0]))
    else $error("gated stage applied early");

  // A crossing ends the wait and loads the stored code
  crossing_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (pending_r[0] && i_zero_cross[0] && !gain_apply_strobe) |=> !pending_r[0] && applied_r[0] == $past(cfg_r[0].code))
    else $error("crossing did not apply pending gain");

  // An expired period ends the wait as a crossing would
  timeout_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (tmo_hit[1] && !gain_apply_strobe) |=> !pending_r[1] && applied_r[1] == $past(cfg_r[1].code))
    else $error("timeout did not apply pending gain");

  // With the timeout off only a crossing may end the wait
  no_timeout_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (!to_en_r && pending_r[0] && !i_zero_cross[0] && !gain_apply_strobe) |=> pending_r[0])
    else $error("pending gain applied with timeout off");

  // Strobe from the last register still moves the first stage
  all_stage_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (apply_strobe[3] && !cfg_r[0].gate) |=> applied_r[0] == $past(cfg_r[0].code))
    else $error("strobe not global");

  // One wait state, then waitrequest back high for the DONE cycle
  wait_one_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (bus_r == gain_pkg::ST_IDLE && req) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  // Read data stands with waitrequest low; update bit always reads zero
  read_update_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (rd_take && sel_stage[1])
    |=> !o_avs_readdata[gain_pkg::BIT_UPDATE] && o_avs_readdata[gain_pkg::CODE_MSB:0] == $past(cfg_r[1].code))
    else $error("stage readback wrong");

  // A stage write stores the code field
  code_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stage[2] |=> cfg_r[2].code == $past(i_avs_writedata[gain_pkg::CODE_MSB:0]))
    else $error("gain code not stored");

  // A stage write stores the crossing gate
  gate_store_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stage[0] |=> cfg_r[0].gate == $past(i_avs_writedata[gain_pkg::BIT_GATE]))
    else $error("crossing gate not stored");

  // Update bit written as zero fires nothing
  strobe_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_acc && !i_avs_writedata[gain_pkg::BIT_UPDATE]) |-> !gain_apply_strobe)
    else $error("strobe fired with update bit zero");

  // Output pins carry the applied codes one edge later
  output_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_noninv_gain_code == {$past(applied_r[3]), $past(applied_r[2]),
                                    $past(applied_r[1]), $past(applied_r[0])})
    else $error("output code does not follow applied code");

  // Before expiry a gated stage with timeout on keeps waiting
  timeout_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (pending_r[1] && to_en_r && !tmo_hit[1] && !i_zero_cross[1] && !gain_apply_strobe) |=> pending_r[1])
    else $error("timeout applied early");

  // Wait counter steps once per cycle while pending with timeout on
  count_step_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (pending_r[1] && to_en_r && !load_now[1] && !gain_apply_strobe) |=> tmo_cnt_r[1] == $past(tmo_cnt_r[1]) + 15'h0001)
    else $error("timeout counter did not step");

  // Timeout enable comes from its own register
  timeout_reg_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_timeout && i_avs_byteenable[1]) |=> to_en_r == $past(i_avs_writedata[gain_pkg::BIT_TO_ENABLE]))
    else $error("timeout enable not stored");

  // Gain register writes leave the timeout setting alone
  stage_apart_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stage[0] |=> $stable(to_en_r) && $stable(period_r))
    else $error("gain write changed timeout setting");

  // A new strobe restarts the wait from zero
  strobe_restart_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (gain_apply_strobe && cfg_r[1].gate) |=> pending_r[1] && tmo_cnt_r[1] == 15'h0000)
    else $error("wait not restarted");

  // Waitrequest is low only while an access completes
  wait_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !o_avs_waitrequest |-> bus_r == gain_pkg::ST_WAIT)
    else $error("waitrequest low outside an access");

  // Status view shows the pending stages
  status_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (rd_take && in_range && {2'h0, word_idx} == gain_pkg::IDX_STATUS) |=> o_avs_readdata[7:4] == $past(pending_r))
    else $error("status readback wrong");

  // Writes to unmapped addresses change nothing
  unmapped_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_acc && !(|sel_stage) && !wr_timeout)
    |=> $stable(cfg_r) && $stable(to_en_r) && $stable(period_r))
    else $error("unmapped write changed a register");

  // A stage write stores the silence bit
  silence_apply_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_stage[3] |=> cfg_r[3].silence == $past(i_avs_writedata[gain_pkg::BIT_SILENCE]))
    else $error("silence bit not stored");

  // Ungated stage never stays pending after a strobe
  pending_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (gain_apply_strobe && !cfg_r[3].gate) |=> !pending_r[3] && applied_r[3] == $past(cfg_r[3].code))
    else $error("ungated stage left pending");

  // No crossing and no expiry: applied code holds
  crossing_only_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (pending_r[0] && !i_zero_cross[0] && !tmo_hit[0] && !gain_apply_strobe) |=> $stable(applied_r[0]))
    else $error("pending gain applied without cause");

  // Waitrequest falls only in answer to a request
  wait_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $fell(o_avs_waitrequest) |-> $past(req))
    else $error("waitrequest fell without request");

endmodule : input_gain_update_control

/* File: inc/gain_pkg.sv */
// Register map, field layout and timing constants of the input gain controller
package gain_pkg;
  localparam int          NUM_STAGES    = 4;
  localparam int          ADDR_W        = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_LEFT_A    = 8'h18;
  localparam logic [7:0]  IDX_LEFT_B    = 8'h19;
  localparam logic [7:0]  IDX_RIGHT_A   = 8'h1A;
  localparam logic [7:0]  IDX_RIGHT_B   = 8'h1B;
  localparam logic [7:0]  IDX_TIMEOUT   = 8'h20;
  localparam logic [7:0]  IDX_STATUS    = 8'h21;
  // Field positions inside a stage register
  localparam int          BIT_UPDATE    = 8;
  localparam int          BIT_SILENCE   = 7;
  localparam int          BIT_GATE      = 6;
  localparam int          CODE_MSB      = 4;
  // Field positions inside the timeout register
  localparam int          BIT_TO_ENABLE = 15;
  localparam int          PERIOD_W      = 15;
  // Reset values, and the word read from unmapped addresses
  localparam logic [4:0]  CODE_RESET    = 5'h0B;
  localparam logic        SILENCE_RESET = 1'b1;
  localparam logic        GATE_RESET    = 1'b0;
  localparam logic        TO_EN_RESET   = 1'b0;
  localparam logic [14:0] PERIOD_RESET  = 15'h0FFF;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // Gain range in tenths of a dB: -16.5 dB at code 0, 1.5 dB per step
  localparam int          GAIN_MIN_TDB  = -165;
  localparam int          GAIN_STEP_TDB = 15;
  localparam int          GAIN_MAX_TDB  = 300;

  // Control bits of one stage
  typedef struct packed {
    logic       silence;
    logic       gate;
    logic [4:0] code;
  } stage_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } bus_state_e;
endpackage : gain_pkg

/* File: tb/tb_top.sv */
// Self-checking bench for the input gain stage controller
`timescale 1ns/1ps
module tb_top;
  logic        i_clk;
  logic        i_rst_b;
  logic [7:0]  i_avs_address;
  logic        i_avs_read;
  logic        i_avs_write;
  logic [31:0] i_avs_writedata;
  logic [3:0]  i_avs_byteenable;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest;
  logic [3:0]  i_zero_cross;
  logic [19:0] o_inv_gain_code;
  logic [19:0] o_noninv_gain_code;
  logic [3:0]  o_stage_silence;
  int          bad_count;
  int          num_checks;
  logic [19:0] exp_code;
  logic [31:0] rd;
  logic [7:0]  idx [4];

  input_gain_update_control u_input_gain_update_control (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_zero_cross(i_zero_cross),
    .o_inv_gain_code(o_inv_gain_code), .o_noninv_gain_code(o_noninv_gain_code),
    .o_stage_silence(o_stage_silence));

  // Clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // One Avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge i_clk);
    i_avs_address    <= addr;
    i_avs_writedata  <= data;
    i_avs_byteenable <= be;
    i_avs_write      <= wr;
    i_avs_read       <= ~wr;
    do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
  endtask : bus

  // Settle past the edge so registered outputs are stable
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wait_cyc

  // Lane 0 only, so the update strobe is never touched here
  task automatic cfg(input int s, input logic sil, input logic gate, input logic [4:0] code);
    bus(1'b1, idx[s] << 2, {24'h0, sil, gate, 1'b0, code}, 4'b0001, rd);
  endtask : cfg

  task automatic strobe(input int s);
    bus(1'b1, idx[s] << 2, 32'h0000_0100, 4'b0010, rd);
  endtask : strobe

  task automatic check_out(input string msg);
    check({12'h0, o_inv_gain_code}, {12'h0, exp_code}, msg);
    check({12'h0, o_noninv_gain_code}, {12'h0, exp_code}, msg);
  endtask : check_out

  task automatic t_reset();
    exp_code = {4{gain_pkg::CODE_RESET}};
    check_out("reset gain");
    check({28'h0, o_stage_silence}, 32'h0000_000F, "reset silence");
    for (int s = 0; s < 4; s++) begin
      bus(1'b0, idx[s] << 2, 32'h0, 4'hF, rd);
      check(rd, 32'h0000_008B, "stage reg reset");
    end
    bus(1'b0, gain_pkg::IDX_TIMEOUT << 2, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_0FFF, "timeout reg reset");
    bus(1'b1, 8'h40, 32'h0000_FFFF, 4'hF, rd);
    bus(1'b0, 8'h40, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_0000, "unmapped read");
  endtask : t_reset

  // Every register serves once as the strobe source, codes rotate over boundaries
  task automatic t_stage();
    logic [4:0] codes [4];
    codes = '{5'h00, 5'h1F, 5'h0B, 5'h15};
    for (int p = 0; p < 4; p++) begin
      for (int s = 0; s < 4; s++) cfg(s, 1'b0, 1'b0, codes[(s + p) % 4]);
      wait_cyc(4);
      check_out("staged write moved gain");
      strobe(p);
      wait_cyc(3);
      for (int s = 0; s < 4; s++) exp_code[5*s +: 5] = codes[(s + p) % 4];
      check_out("strobe apply");
      check({28'h0, o_stage_silence}, 32'h0, "unmute");
      bus(1'b0, idx[p] << 2, 32'h0, 4'hF, rd);
      check(rd, {27'h0, codes[(2 * p) % 4]}, "readback, update reads 0");
    end
  endtask : t_stage

  task automatic t_zero_write();
    bus(1'b1, idx[1] << 2, 32'h0000_0007, 4'b0011, rd);
    wait_cyc(6);
    check_out("update written 0");
  endtask : t_zero_write

  // Gated stage waits for its crossing; timeout disabled at this point
  task automatic t_gate();
    cfg(0, 1'b0, 1'b1, 5'h03);
    cfg(3, 1'b1, 1'b0, 5'h1A);
    strobe(2);
    wait_cyc(3);
    // Stage 1 stored code 7 with update 0 earlier; this strobe applies it
    exp_code[5 +: 5]  = 5'h07;
    exp_code[15 +: 5] = 5'h1A;
    check_out("ungated stage applies");
    check({28'h0, o_stage_silence}, 32'h0000_0008, "mute one stage");
    wait_cyc(12);
    check_out("gated stage held");
    bus(1'b0, gain_pkg::IDX_STATUS << 2, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_0010, "stage 0 pending");
    @(posedge i_clk);
    i_zero_cross <= 4'b0001;
    @(posedge i_clk);
    i_zero_cross <= 4'b0000;
    wait_cyc(3);
    exp_code[0 +: 5] = 5'h03;
    check_out("crossing applies");
  endtask : t_gate

  // Period of 8 cycles, no crossing ever arrives
  task automatic t_timeout();
    bus(1'b1, gain_pkg::IDX_TIMEOUT << 2, 32'h0000_8008, 4'b0011, rd);
    bus(1'b0, gain_pkg::IDX_TIMEOUT << 2, 32'h0, 4'hF, rd);
    check(rd, 32'h0000_8008, "timeout reg readback");
    cfg(1, 1'b0, 1'b1, 5'h1C);
    strobe(1);
    wait_cyc(3);
    check_out("timeout not yet expired");
    wait_cyc(20);
    exp_code[5 +: 5] = 5'h1C;
    check_out("timeout applies");
  endtask : t_timeout

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // Watchdog well past the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    idx = '{gain_pkg::IDX_LEFT_A, gain_pkg::IDX_LEFT_B, gain_pkg::IDX_RIGHT_A, gain_pkg::IDX_RIGHT_B};
    i_rst_b = 1'b0;
    i_avs_address = 8'h00;
    i_avs_read = 1'b0;
    i_avs_write = 1'b0;
    i_avs_writedata = 32'h0;
    i_avs_byteenable = 4'h0;
    i_zero_cross = 4'h0;
    bad_count = 0;
    num_checks = 0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    wait_cyc(2);
    t_reset();
    t_stage();
    t_zero_write();
    t_gate();
    t_timeout();
    summarize();
  end
endmodule : tb_top
